// *** logic/fcl_pkg.sv ***
package fcl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB slave.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_NUM = 12'h004;
  localparam logic [11:0] OFS_DEN = 12'h008;
  localparam logic [11:0] OFS_LIMIT = 12'h00C;
  localparam logic [11:0] OFS_REVS = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h018;
  localparam logic [11:0] OFS_IRQ_EN = 12'h01C;
  localparam logic [11:0] OFS_DEV_LO = 12'h020;
  localparam logic [11:0] OFS_DEV_HI = 12'h024;
  localparam logic [11:0] OFS_SCALE_CNT = 12'h028;
  localparam logic [11:0] OFS_ENC_CNT = 12'h02C;
  localparam logic [11:0] OFS_ERR_CODE = 12'h030;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the control register.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_INV = 2;
  localparam int CTRL_EN = 3;

  // Sticky status bits; the enable and clear registers share this layout.
  localparam int ST_EXCESS = 0;
  localparam int ST_CLEARED = 1;
  localparam int ST_INVALID = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and setting ranges.
  localparam logic [20:0] NUM_RST = 21'h000001;
  localparam logic [20:0] NUM_MAX = 21'h100000;
  localparam logic [20:0] DEN_RST = 21'h000001;
  localparam logic [20:0] DEN_MIN = 21'h000001;
  localparam logic [20:0] DEN_MAX = 21'h100000;
  localparam logic [27:0] LIMIT_RST = 28'h0000064;
  localparam logic [27:0] LIMIT_MIN = 28'h0000001;
  localparam logic [6:0] REVS_RST = 7'h00;
  localparam logic [6:0] REVS_MAX = 7'h64;
  localparam int LIMIT_UNIT_SHIFT = 4;
  localparam logic [7:0] ERR_CODE_EXCESS = 8'h19;

  typedef enum logic [1:0] {
    SCALE_QUAD,
    SCALE_SER_MSB,
    SCALE_SER_LSB
  } scale_type_e;

  typedef struct packed {
    scale_type_e scale_type_select;
    logic scale_direction_invert;
    logic enable;
    logic [20:0] scale_ratio_numerator;
    logic [20:0] scale_ratio_denominator;
    logic [27:0] deviation_excess_limit;
    logic [6:0] deviation_clear_revolutions;
  } cfg_s;

endpackage

// *** logic/full_closed_scale_feedback.sv ***
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Hybrid deviation is encoder position minus scaled scale position, always.
// - Deviation magnitude above limit raises the excess error and its code.
// - Limit counts in 16 scale pulses, never below one.
// - Deviation returns to zero after the set revolutions; setting 0 to 100.
// - Scale type selection takes values zero through two.
// - Quadrature A/B scales and serial position scales are both accepted.
// - Direction bit set to one inverts the scale count direction.
// - Scale counts scaled by numerator over denominator; denominator at least one.
module full_closed_scale_feedback (
  input wire logic pclk, // APB clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, no wait states.
  output logic pslverr, // APB error on unmapped address.
  input wire logic scale_a, // Scale phase A pin.
  input wire logic scale_b, // Scale phase B pin.
  input wire logic scale_sclk, // Serial scale bit clock pin.
  input wire logic scale_sdata, // Serial scale data pin.
  input wire logic scale_frame, // Serial scale frame pin, high during a word.
  input wire logic [31:0] enc_pos, // Motor encoder position, same clock.
  input wire logic enc_rev_tick, // One pulse per motor revolution, same clock.
  output logic irq, // Level interrupt.
  output logic deviation_excess_error, // Excess deviation error flag.
  output logic [7:0] error_code // Error code, following the error flag one cycle later.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  fcl_pkg::cfg_s cfg_q;
  logic [fcl_pkg::ST_W-1:0] status_q, irq_en_q, st_set, st_clr;
  logic [4:0] sync1_q, sync2_q;
  logic [1:0] ab_q;
  logic sclk_q, frame_q, have_word_q, enc_started_q;
  logic [31:0] shift_q, last_word_q, enc_prev_q;
  logic signed [31:0] scale_cnt_q, enc_cnt_q;
  logic [31:0] raw_step, scale_step, enc_step;
  logic invalid_ev, frame_done, one_chg, both_chg, count_up;
  logic [6:0] rev_cnt_q;
  logic rev_clear;
  logic [53:0] prod_e_q, prod_s_q, thr_q, dev, dev_mag;
  logic excess;
  logic wr_en, setup_rd;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [7:0] err_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else if (clk_en) begin
      sync1_q <= {scale_frame, scale_sdata, scale_sclk, scale_b, scale_a};
      sync2_q <= sync1_q;
    end
  end

  // Previous levels of the synchronised pins for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_q <= 2'h0;
      sclk_q <= 1'b0;
      frame_q <= 1'b0;
    end else if (clk_en) begin
      ab_q <= sync2_q[1:0];
      sclk_q <= sync2_q[2];
      frame_q <= sync2_q[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature decode; a gray step gives one count, a double change is dropped.
  assign one_chg = ^(ab_q ^ sync2_q[1:0]);
  assign both_chg = &(ab_q ^ sync2_q[1:0]);
  // With A leading B the old A matches the new B.
  assign count_up = (ab_q[0] == sync2_q[1]);

  // Serial shifter; bit order depends on the selected serial type.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 32'h00000000;
    end else if (clk_en && sync2_q[4] && sync2_q[2] && !sclk_q) begin
      if (cfg_q.scale_type_select == fcl_pkg::SCALE_SER_LSB) begin
        shift_q <= {sync2_q[3], shift_q[31:1]};
      end else begin
        shift_q <= {shift_q[30:0], sync2_q[3]};
      end
    end
  end

  // The first word only sets the reference, so power-up gives no jump.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word_q <= 32'h00000000;
      have_word_q <= 1'b0;
    end else if (clk_en && frame_done) begin
      last_word_q <= shift_q;
      have_word_q <= 1'b1;
    end
  end

  // One step of the scale counter per cycle from whichever type is chosen.
  always_comb begin
    raw_step = 32'h00000000;
    invalid_ev = 1'b0;
    frame_done = 1'b0;
    case (cfg_q.scale_type_select)
      fcl_pkg::SCALE_QUAD: begin
        invalid_ev = both_chg;
        if (one_chg) begin
          raw_step = count_up ? 32'h00000001 : 32'hFFFFFFFF;
        end
      end
      fcl_pkg::SCALE_SER_MSB, fcl_pkg::SCALE_SER_LSB: begin
        frame_done = frame_q && !sync2_q[4];
        if (frame_done && have_word_q) begin
          raw_step = shift_q - last_word_q;
        end
      end
      default: begin
        raw_step = 32'h00000000;
      end
    endcase
  end

  assign scale_step = cfg_q.scale_direction_invert ? (32'h00000000 - raw_step) : raw_step;

  ////////////////////////////////////////////////////////////////////////////
  // Encoder movement since the last cycle; the first sample only seeds it.
  assign enc_step = enc_started_q ? (enc_pos - enc_prev_q) : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_prev_q <= 32'h00000000;
      enc_started_q <= 1'b0;
    end else if (clk_en) begin
      enc_prev_q <= enc_pos;
      enc_started_q <= 1'b1;
    end
  end

  // Revolution counter; zero disables the periodic clear.
  assign rev_clear = enc_rev_tick && (cfg_q.deviation_clear_revolutions != 7'h00) &&
                     ((rev_cnt_q + 7'h01) >= cfg_q.deviation_clear_revolutions);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_cnt_q <= 7'h00;
    end else if (clk_en && enc_rev_tick) begin
      rev_cnt_q <= rev_clear ? 7'h00 : rev_cnt_q + 7'h01;
    end
  end

  // Both counters restart together so the deviation returns to zero.
  // The step of the clearing cycle is kept so no movement is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_cnt_q <= 32'sh00000000;
      enc_cnt_q <= 32'sh00000000;
    end else if (clk_en) begin
      if (rev_clear) begin
        scale_cnt_q <= scale_step;
        enc_cnt_q <= enc_step;
      end else begin
        scale_cnt_q <= scale_cnt_q + scale_step;
        enc_cnt_q <= enc_cnt_q + enc_step;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cross-multiplying avoids a divider: the deviation is held in units of
  // one scale pulse divided by the numerator. Costs one cycle of latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod_e_q <= 54'h0;
      prod_s_q <= 54'h0;
      thr_q <= 54'h0;
    end else if (clk_en) begin
      prod_e_q <= {{22{enc_cnt_q[31]}}, enc_cnt_q} *
                  {33'h0, cfg_q.scale_ratio_denominator};
      prod_s_q <= {{22{scale_cnt_q[31]}}, scale_cnt_q} *
                  {33'h0, cfg_q.scale_ratio_numerator};
      thr_q <= {22'h0, cfg_q.deviation_excess_limit, 4'h0} *
               {33'h0, cfg_q.scale_ratio_numerator};
    end
  end

  assign dev = prod_e_q - prod_s_q;
  assign dev_mag = dev[53] ? (54'h0 - dev) : dev;
  assign excess = cfg_q.enable && (dev_mag > thr_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; out-of-range values are clamped or refused.
  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{fcl_pkg::SCALE_QUAD, 1'b0, 1'b0, fcl_pkg::NUM_RST, fcl_pkg::DEN_RST,
                 fcl_pkg::LIMIT_RST, fcl_pkg::REVS_RST};
    end else if (clk_en && wr_en) begin
      case (paddr)
        fcl_pkg::OFS_CTRL: begin
          if (pwdata[fcl_pkg::CTRL_TYPE_LSB+:2] != 2'h3) begin
            cfg_q.scale_type_select <= fcl_pkg::scale_type_e'(pwdata[fcl_pkg::CTRL_TYPE_LSB+:2]);
          end
          cfg_q.scale_direction_invert <= pwdata[fcl_pkg::CTRL_INV];
          cfg_q.enable <= pwdata[fcl_pkg::CTRL_EN];
        end
        fcl_pkg::OFS_NUM: begin
          cfg_q.scale_ratio_numerator <= (pwdata > {11'h0, fcl_pkg::NUM_MAX}) ?
                                         fcl_pkg::NUM_MAX : pwdata[20:0];
        end
        fcl_pkg::OFS_DEN: begin
          if (pwdata == 32'h00000000) begin
            cfg_q.scale_ratio_denominator <= fcl_pkg::DEN_MIN;
          end else if (pwdata > {11'h0, fcl_pkg::DEN_MAX}) begin
            cfg_q.scale_ratio_denominator <= fcl_pkg::DEN_MAX;
          end else begin
            cfg_q.scale_ratio_denominator <= pwdata[20:0];
          end
        end
        fcl_pkg::OFS_LIMIT: begin
          cfg_q.deviation_excess_limit <= (pwdata[27:0] == 28'h0) ?
                                          fcl_pkg::LIMIT_MIN : pwdata[27:0];
        end
        fcl_pkg::OFS_REVS: begin
          cfg_q.deviation_clear_revolutions <= (pwdata > {25'h0, fcl_pkg::REVS_MAX}) ?
                                               fcl_pkg::REVS_MAX : pwdata[6:0];
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // Interrupt enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= 4'h0;
    end else if (clk_en && wr_en && paddr == fcl_pkg::OFS_IRQ_EN) begin
      irq_en_q <= pwdata[fcl_pkg::ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: an event in the clearing cycle survives the clear.
  always_comb begin
    st_set = 4'h0;
    st_set[fcl_pkg::ST_EXCESS] = excess;
    st_set[fcl_pkg::ST_CLEARED] = rev_clear;
    st_set[fcl_pkg::ST_INVALID] = invalid_ev;
    st_set[fcl_pkg::ST_FRAME] = frame_done;
  end

  assign st_clr = (wr_en && paddr == fcl_pkg::OFS_IRQ_CLR) ? pwdata[fcl_pkg::ST_W-1:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 4'h0;
    end else if (clk_en) begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // Error code follows the excess flag one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code_q <= 8'h00;
    end else if (clk_en) begin
      err_code_q <= status_q[fcl_pkg::ST_EXCESS] ? fcl_pkg::ERR_CODE_EXCESS : 8'h00;
    end
  end

  assign irq = |(status_q & irq_en_q);
  assign deviation_excess_error = status_q[fcl_pkg::ST_EXCESS];
  assign error_code = err_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; the write-only clear register and holes answer with error.
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      fcl_pkg::OFS_CTRL: rd_mux = {28'h0, cfg_q.enable, cfg_q.scale_direction_invert,
                                   cfg_q.scale_type_select};
      fcl_pkg::OFS_NUM: rd_mux = {11'h0, cfg_q.scale_ratio_numerator};
      fcl_pkg::OFS_DEN: rd_mux = {11'h0, cfg_q.scale_ratio_denominator};
      fcl_pkg::OFS_LIMIT: rd_mux = {4'h0, cfg_q.deviation_excess_limit};
      fcl_pkg::OFS_REVS: rd_mux = {25'h0, cfg_q.deviation_clear_revolutions};
      fcl_pkg::OFS_STATUS: rd_mux = {28'h0, status_q};
      fcl_pkg::OFS_IRQ_EN: rd_mux = {28'h0, irq_en_q};
      fcl_pkg::OFS_DEV_LO: rd_mux = dev[31:0];
      fcl_pkg::OFS_DEV_HI: rd_mux = {{10{dev[53]}}, dev[53:32]};
      fcl_pkg::OFS_SCALE_CNT: rd_mux = scale_cnt_q;
      fcl_pkg::OFS_ENC_CNT: rd_mux = enc_cnt_q;
      fcl_pkg::OFS_ERR_CODE: rd_mux = {24'h0, err_code_q};
      fcl_pkg::OFS_IRQ_CLR: rd_err = !pwrite;
      default: rd_err = 1'b1;
    endcase
  end

  // Read data and error are captured in the setup cycle, shown in access.
  assign setup_rd = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en && setup_rd) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // Every access completes in its first access cycle.
  assign pready = 1'b1;

endmodule

`default_nettype wire

// *** bench/fcl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks for the scale feedback block.
module fcl_properties (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic clk_en, // Clock enable.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error response.
  input wire logic irq, // Interrupt.
  input wire logic deviation_excess_error, // Excess flag.
  input wire logic [7:0] error_code // Error code.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup_c = clk_en && psel && !penable;
  wire logic wr_c = clk_en && psel && penable && pwrite;
  logic clr_q;
  logic wr_q;

  // Marks a write taken in the previous cycle, so a falling flag can be traced to it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      clr_q <= wr_c && paddr == fcl_pkg::OFS_IRQ_CLR && pwdata[fcl_pkg::ST_EXCESS];
      wr_q <= wr_c;
    end
  end

  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready low in a transfer");
  property p_code_set; clk_en && deviation_excess_error |=> error_code == 8'h19; endproperty
  a_code_set: assert property (p_code_set) else $error("error code absent");
  property p_code_clr; clk_en && !deviation_excess_error |=> error_code == 8'h00; endproperty
  a_code_clr: assert property (p_code_clr) else $error("error code stale");
  property p_unmapped; setup_c && paddr > 12'h030 |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped slot accepted");
  property p_mapped;
    setup_c && paddr <= 12'h030 && paddr[1:0] == 2'h0 && (pwrite || paddr != 12'h018)
      |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped slot refused");
  property p_wr_zero; setup_c && pwrite |=> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
  property p_stand; clk_en && !(psel && !penable) |=> $stable(prdata) && $stable(pslverr); endproperty
  a_stand: assert property (p_stand) else $error("answer changed outside setup");
  property p_sticky; $fell(deviation_excess_error) |-> clr_q; endproperty
  a_sticky: assert property (p_sticky) else $error("excess flag dropped alone");
  property p_irq_fall; $fell(irq) |-> wr_q; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
endmodule

bind full_closed_scale_feedback fcl_properties i_fcl_properties (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .deviation_excess_error(deviation_excess_error), .error_code(error_code));

`default_nettype wire

// *** bench/scale_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// External scale: quadrature phases or framed serial words, paced by pclk.
module scale_model (
  input wire logic pclk, // Pacing clock.
  output logic scale_a, // Phase A.
  output logic scale_b, // Phase B.
  output logic scale_sclk, // Bit clock, still outside frames.
  output logic scale_sdata, // Data line.
  output logic scale_frame // High during a word.
);
  // Idle lines at time zero.
  initial begin
    scale_a = 1'b0;
    scale_b = 1'b0;
    scale_sclk = 1'b0;
    scale_sdata = 1'b1;
    scale_frame = 1'b0;
  end

  // Forward order 00,10,11,01 keeps phase A ahead of B.
  task automatic quad(input int n, input bit rev);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      if ((scale_a ^ scale_b) ^ rev) begin
        scale_b <= ~scale_b;
      end else begin
        scale_a <= ~scale_a;
      end
    end
  endtask

  // Both phases at once is a broken signal, sent only on request.
  task automatic both();
    repeat (4) @(posedge pclk);
    scale_a <= ~scale_a;
    scale_b <= ~scale_b;
  endtask

  // Slow bit clock so the synchronisers see every level; the data line is
  // left toggled after the frame because it has no pull.
  task automatic word(input logic [31:0] w, input bit lsb);
    @(posedge pclk);
    scale_frame <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      scale_sdata <= lsb ? w[i] : w[31 - i];
      repeat (3) @(posedge pclk);
      scale_sclk <= 1'b1;
      repeat (3) @(posedge pclk);
      scale_sclk <= 1'b0;
    end
    repeat (3) @(posedge pclk);
    scale_frame <= 1'b0;
    scale_sdata <= ~scale_sdata;
    repeat (6) @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// *** bench/full_closed_scale_feedback_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module full_closed_scale_feedback_test;
  typedef struct {logic [31:0] d; logic e; string n;} note_s;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, enc_rev_tick = 1'b0, pready, pslverr, irq, deviation_excess_error;
  logic scale_a, scale_b, scale_sclk, scale_sdata, scale_frame;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, enc_pos = 32'h0, prdata;
  logic [7:0] error_code;
  int failures = 0, checks_done = 0;
  int unsigned n1, n2;
  note_s notes[$];
  note_s nt;

  always #2 pclk = ~pclk;

  full_closed_scale_feedback i_full_closed_scale_feedback (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scale_a(scale_a),
    .scale_b(scale_b), .scale_sclk(scale_sclk), .scale_sdata(scale_sdata),
    .scale_frame(scale_frame), .enc_pos(enc_pos), .enc_rev_tick(enc_rev_tick), .irq(irq),
    .deviation_excess_error(deviation_excess_error), .error_code(error_code));
  scale_model i_scale_model (.pclk(pclk), .scale_a(scale_a), .scale_b(scale_b),
    .scale_sclk(scale_sclk), .scale_sdata(scale_sdata), .scale_frame(scale_frame));

  ////////////////////////////////////////
  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One bus transfer; its expected answer is noted before the access ends.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    @(posedge pclk);
    notes.push_back('{w ? 32'h0 : x, xe, $sformatf("reg %h", a)});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, x, 1'b0);
  endtask
  // Encoder moves by a step; ends settled on a falling edge.
  task automatic enc(input logic [31:0] s);
    @(posedge pclk);
    enc_pos <= enc_pos + s;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic tick();
    @(posedge pclk);
    enc_rev_tick <= 1'b1;
    @(posedge pclk);
    enc_rev_tick <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  // Takes the oldest note whenever a transfer completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      cmp_word(nt.n, nt.d, prdata);
      cmp_bit(nt.n, nt.e, pslverr);
    end
  end

  // Cuts a hang short; the run needs far fewer cycles.
  initial begin
    #80000;
    failures++;
    final_report();
  end

  initial begin
    void'($urandom(64078));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(fcl_pkg::OFS_CTRL, 32'h0);
    rd(fcl_pkg::OFS_DEN, 32'h1);
    rd(fcl_pkg::OFS_LIMIT, 32'h64);
    rd(fcl_pkg::OFS_REVS, 32'h0);
    apb(1'b0, 12'h034, 32'h0, 32'h0, 1'b1);
    apb(1'b0, fcl_pkg::OFS_IRQ_CLR, 32'h0, 32'h0, 1'b1);
    // Out-of-range settings land on the nearest legal value.
    wr(fcl_pkg::OFS_DEN, 32'h0);
    rd(fcl_pkg::OFS_DEN, 32'h1);
    wr(fcl_pkg::OFS_NUM, 32'h1FFFFF);
    rd(fcl_pkg::OFS_NUM, 32'h100000);
    wr(fcl_pkg::OFS_LIMIT, 32'h0);
    rd(fcl_pkg::OFS_LIMIT, 32'h1);
    wr(fcl_pkg::OFS_REVS, 32'h7F);
    rd(fcl_pkg::OFS_REVS, 32'h64);
    n1 = $urandom_range(32'h100000, 0);
    wr(fcl_pkg::OFS_NUM, n1);
    rd(fcl_pkg::OFS_NUM, n1);
    for (int t = 0; t < 4; t++) begin
      wr(fcl_pkg::OFS_CTRL, t);
      rd(fcl_pkg::OFS_CTRL, (t == 3) ? 32'h2 : t);
    end
    // Quadrature forward, then forward again with the direction bit inverted, then a double edge that must not count.
    wr(fcl_pkg::OFS_CTRL, 32'h0);
    n1 = $urandom_range(20, 1);
    n2 = $urandom_range(20, 1);
    i_scale_model.quad(n1, 1'b0);
    repeat (8) @(posedge pclk);
    rd(fcl_pkg::OFS_SCALE_CNT, n1);
    wr(fcl_pkg::OFS_CTRL, 32'h4);
    i_scale_model.quad(n2, 1'b0);
    i_scale_model.both();
    repeat (8) @(posedge pclk);
    rd(fcl_pkg::OFS_SCALE_CNT, n1 - n2);
    rd(fcl_pkg::OFS_STATUS, 32'h4);
    @(negedge pclk);
    cmp_bit("irq masked", 1'b0, irq);
    wr(fcl_pkg::OFS_IRQ_EN, 32'h4);
    @(negedge pclk);
    cmp_bit("irq raised", 1'b1, irq);
    wr(fcl_pkg::OFS_IRQ_CLR, 32'h4);
    @(negedge pclk);
    cmp_bit("irq cleared", 1'b0, irq);
    // First frame only seeds; later frames add the difference, per bit order.
    wr(fcl_pkg::OFS_CTRL, 32'h1);
    i_scale_model.word(32'h00000010, 1'b0);
    i_scale_model.word(32'h00000015, 1'b0);
    wr(fcl_pkg::OFS_CTRL, 32'h2);
    i_scale_model.word(32'h0000001A, 1'b1);
    rd(fcl_pkg::OFS_SCALE_CNT, n1 - n2 + 10);
    rd(fcl_pkg::OFS_STATUS, 32'h8);
    // Zero both counters, then step across the limit of 16 pulses.
    wr(fcl_pkg::OFS_REVS, 32'h1);
    tick();
    rd(fcl_pkg::OFS_DEV_LO, 32'h0);
    wr(fcl_pkg::OFS_NUM, 32'h1);
    wr(fcl_pkg::OFS_CTRL, 32'h8);
    enc(32'd16);
    cmp_bit("excess", 1'b0, deviation_excess_error);
    enc(32'd1);
    cmp_bit("excess", 1'b1, deviation_excess_error);
    rd(fcl_pkg::OFS_DEV_LO, 32'd17);
    rd(fcl_pkg::OFS_ERR_CODE, 32'h19);
    cmp_word("error code", 32'h19, {24'h0, error_code});
    enc(32'hFFFFFFFF);
    wr(fcl_pkg::OFS_IRQ_CLR, 32'hF);
    @(negedge pclk);
    cmp_bit("excess", 1'b0, deviation_excess_error);
    // Clear after two revolutions, not one.
    wr(fcl_pkg::OFS_REVS, 32'h2);
    cmp_word("error code", 32'h0, {24'h0, error_code});
    tick();
    rd(fcl_pkg::OFS_DEV_LO, 32'd16);
    rd(fcl_pkg::OFS_STATUS, 32'h0);
    tick();
    rd(fcl_pkg::OFS_DEV_LO, 32'h0);
    rd(fcl_pkg::OFS_STATUS, 32'h2);
    // Ratio 3/2: two scale pulses balance three encoder counts.
    wr(fcl_pkg::OFS_NUM, 32'h3);
    wr(fcl_pkg::OFS_DEN, 32'h2);
    i_scale_model.quad(2, 1'b0);
    repeat (8) @(posedge pclk);
    rd(fcl_pkg::OFS_DEV_LO, 32'hFFFFFFFA);
    rd(fcl_pkg::OFS_DEV_HI, 32'hFFFFFFFF);
    enc(32'd3);
    rd(fcl_pkg::OFS_DEV_LO, 32'h0);
    rd(fcl_pkg::OFS_DEV_HI, 32'h0);
    // Frozen cycles count no revolution, yet the encoder motion is not lost.
    @(posedge pclk);
    clk_en <= 1'b0;
    enc(32'd5);
    tick();
    @(posedge pclk);
    clk_en <= 1'b1;
    tick();
    rd(fcl_pkg::OFS_DEV_LO, 32'd10);
    rd(fcl_pkg::OFS_ENC_CNT, 32'd8);
    final_report();
  end
endmodule

`default_nettype wire
